// [logic/sfod_defines.vh]
`ifndef SFOD_DEFINES_VH
`define SFOD_DEFINES_VH

// Opcodes.
`define SFOD_OP_FAST_ARRAY_FETCH 8'h0B
`define SFOD_OP_ARRAY_FETCH 8'h03
`define SFOD_OP_DUAL_OUTPUT_FETCH 8'h3B
`define SFOD_OP_DUAL_IO_FETCH 8'hBB
`define SFOD_OP_QUAD_OUTPUT_FETCH 8'h6B
`define SFOD_OP_QUAD_IO_FETCH 8'hEB
`define SFOD_OP_PAGE_WIPE 8'h81
`define SFOD_OP_SMALL_UNIT_WIPE 8'h20
`define SFOD_OP_HALF_BLOCK_WIPE 8'h52
`define SFOD_OP_FULL_BLOCK_WIPE 8'hD8
`define SFOD_OP_CHIP_WIPE 8'h60
`define SFOD_OP_CHIP_WIPE_ALT 8'hC7
`define SFOD_OP_PAGE_WRITE 8'h02
`define SFOD_OP_DUAL_PAGE_WRITE 8'hA2
`define SFOD_OP_QUAD_PAGE_WRITE 8'h32
`define SFOD_OP_PAUSE_CMD 8'h75
`define SFOD_OP_PAUSE_CMD_ALT 8'hB0
`define SFOD_OP_CONTINUE_CMD 8'h7A
`define SFOD_OP_CONTINUE_CMD_ALT 8'h30
`define SFOD_OP_WRITE_LATCH_SET 8'h06
`define SFOD_OP_WRITE_LATCH_CLEAR 8'h04
`define SFOD_OP_VOLATILE_LATCH_SET 8'h50
`define SFOD_OP_SECURE_AREA_WIPE 8'h44
`define SFOD_OP_SECURE_AREA_WRITE 8'h42
`define SFOD_OP_SECURE_AREA_FETCH 8'h48
`define SFOD_OP_STATE_FETCH_LOW 8'h05
`define SFOD_OP_STATE_FETCH_HIGH 8'h35
`define SFOD_OP_CONFIG_FETCH 8'h15
`define SFOD_OP_ACTIVITY_INTERRUPT_ARM 8'h25
`define SFOD_OP_STATE_STORE 8'h01
`define SFOD_OP_CONFIG_STORE 8'h11
`define SFOD_OP_RESET_ARM 8'h66
`define SFOD_OP_RESET 8'h99
`define SFOD_OP_IDENT_TRIPLET_FETCH 8'h9F
`define SFOD_OP_MAKER_PART_FETCH 8'h90
`define SFOD_OP_DUAL_MAKER_PART_FETCH 8'h92
`define SFOD_OP_QUAD_MAKER_PART_FETCH 8'h94
`define SFOD_OP_DEEP_SLEEP_ENTER 8'hB9
`define SFOD_OP_WAKE_IDENT_FETCH 8'hAB
`define SFOD_OP_BURST_LEN_SET 8'h77
`define SFOD_OP_UNIQUE_SERIAL_FETCH 8'h4B

// Frame descriptor field positions.
`define SFOD_F_VALID 15
`define SFOD_F_ADDR3 14
`define SFOD_F_DUMMY_HI 13
`define SFOD_F_DUMMY_LO 11
`define SFOD_F_ALANE_HI 10
`define SFOD_F_ALANE_LO 9
`define SFOD_F_DLANE_HI 8
`define SFOD_F_DLANE_LO 7
`define SFOD_F_OUT 6
`define SFOD_F_IN 5
`define SFOD_F_WR 4
`define SFOD_F_QUAD 3
`define SFOD_F_FIFO 2
`define SFOD_F_DSPEC_HI 1
`define SFOD_F_DSPEC_LO 0

// Data byte count codes and lane codes.
`define SFOD_DS_NONE 2'h0
`define SFOD_DS_ONE 2'h1
`define SFOD_DS_TWO 2'h2
`define SFOD_DS_MANY 2'h3
`define SFOD_LN_X1 2'h0
`define SFOD_LN_X2 2'h1
`define SFOD_LN_X4 2'h2

// Status bit positions in the low status byte.
`define SFOD_SR_BUSY 0
`define SFOD_SR_WEL 1

`define SFOD_ADDR_BYTES 3'h3
`define SFOD_IDLE_BYTE 8'hFF

`endif

// [logic/sfod_fifo.v]
module sfod_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_flush,
  input wire [WIDTH-1:0] i_data,
  input wire i_valid,
  output wire o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire o_valid,
  input wire i_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  assign o_ready = (count_q != DEPTH[AW:0]);
  assign o_valid = (count_q != {(AW+1){1'b0}});
  assign o_data = mem[rd_ptr_q];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= i_data;
    end
  end

  always @(posedge i_clk) begin
    if (i_reset || i_flush) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // sfod_fifo

// [logic/sfod_decoder.v]
// Behaviour
// R1: Opcode 0Bh takes 3 address, 1 dummy byte, streams data until deselect.
// R2: Opcode 03h takes 3 address bytes, no dummy, streams data on one line.
// R3: Opcode 3Bh takes 3 serial address bytes, 1 dummy, data on two lanes.
// R4: Opcode BBh takes address and dummy on two lanes, data on two lanes.
// R5: Opcode 6Bh takes 3 address, 1 dummy byte, data on four lanes.
// R6: Opcode EBh takes address and dummy on four lanes, data on four lanes.
// R7: Opcode 20h takes 3 address bytes, no data, wipes a 4K sector.
// R8: Opcode 52h takes 3 address bytes, no data, wipes a 32K block.
// R9: Opcode D8h takes 3 address bytes, no data, wipes a 64K block.
// R10: Opcode A2h takes 3 address bytes then data bytes on two lanes.
// R11: Opcode 32h takes 3 address bytes then data bytes on four lanes.
// R12: Opcode 06h alone sets the write latch flag.
// R13: Opcode 04h alone clears the write latch flag.
// R14: Opcode 50h makes the next status store touch volatile bits only.
// R15: Opcode 48h takes 3 address, 1 dummy byte, returns security bytes.
// R16: Opcode 05h returns the low status byte directly.
// R17: Opcode 35h returns the high status byte directly.
// R18: Opcode 15h returns the configuration byte directly.
// R19: Opcode 25h takes one dummy byte, no data, arms activity interrupt.
// R20: Opcode 01h takes two data bytes, no address, stores status.
// R21: Opcode 9Fh returns maker code then two device code bytes.
// R22: Opcode ABh takes 3 address bytes, returns one identification byte.
// R23: Unknown opcode floats output and ignores clocks until next select.
// R24: Chip wipe, pause and continue each accept two equivalent opcodes.
// R25: Host ends write, wipe, latch and reset frames on a byte boundary.
// R26: Four-lane fetch and write commands need the quad allow bit.
// R27: Write latch clears when a write, wipe or reset command completes.
// R28: Low status bit 0 shows busy, bit 1 shows the write latch.
`include "sfod_defines.vh"

module sfod_decoder #(
  parameter [7:0] MAKER_CODE = 8'h5A,
  parameter [15:0] DEVICE_CODE = 16'hA5_01,
  parameter [7:0] WAKE_IDENT = 8'h3C,
  parameter FIFO_DEPTH = 32
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_sclk,
  input wire i_cs_n,
  input wire [3:0] i_io,
  output reg [3:0] o_io,
  output reg [3:0] o_io_oe_n,
  input wire i_busy_flag,
  input wire [5:0] i_status_low_upper,
  input wire [7:0] i_status_high,
  input wire [7:0] i_config,
  input wire i_quad_allow_bit,
  input wire i_op_done,
  input wire [7:0] i_rd_data,
  input wire i_rd_valid,
  output wire o_rd_ready,
  output reg o_cmd_valid,
  output reg [7:0] o_cmd_code,
  output reg [23:0] o_cmd_addr,
  output reg o_cmd_volatile,
  output reg o_wr_valid,
  output reg [7:0] o_wr_byte,
  output wire o_write_latch_flag
);
  localparam [6:0] ST_OP = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_DUMMY = 7'h04;
  localparam [6:0] ST_DIN = 7'h08;
  localparam [6:0] ST_DOUT = 7'h10;
  localparam [6:0] ST_DONE = 7'h20;
  localparam [6:0] ST_IGNORE = 7'h40;

  // Builds a frame descriptor from its fields.
  function [15:0] frame;
    input a3;
    input [2:0] dmy;
    input [1:0] al;
    input [1:0] dl;
    input out;
    input din;
    input wr;
    input quad;
    input fifo;
    input [1:0] ds;
    begin
      frame = {1'b1, a3, dmy, al, dl, out, din, wr, quad, fifo, ds};
    end
  endfunction

  // Maps an opcode to its frame descriptor; zero means unknown.
  function [15:0] decode;
    input [7:0] op;
    begin
      case (op)
        // R1: fast fetch.
        `SFOD_OP_FAST_ARRAY_FETCH: decode = frame(1, 1, 0, 0, 1, 0, 0, 0, 1, `SFOD_DS_MANY);
        // R2: plain fetch.
        `SFOD_OP_ARRAY_FETCH: decode = frame(1, 0, 0, 0, 1, 0, 0, 0, 1, `SFOD_DS_MANY);
        // R3: dual output.
        `SFOD_OP_DUAL_OUTPUT_FETCH: decode = frame(1, 1, 0, 1, 1, 0, 0, 0, 1, `SFOD_DS_MANY);
        // R4: dual lanes.
        `SFOD_OP_DUAL_IO_FETCH: decode = frame(1, 1, 1, 1, 1, 0, 0, 0, 1, `SFOD_DS_MANY);
        // R5: quad output.
        `SFOD_OP_QUAD_OUTPUT_FETCH: decode = frame(1, 1, 0, 2, 1, 0, 0, 1, 1, `SFOD_DS_MANY);
        // R6: quad lanes.
        `SFOD_OP_QUAD_IO_FETCH: decode = frame(1, 1, 2, 2, 1, 0, 0, 1, 1, `SFOD_DS_MANY);
        `SFOD_OP_PAGE_WIPE: decode = frame(1, 0, 0, 0, 0, 0, 1, 0, 0, `SFOD_DS_NONE);
        // R7: sector wipe.
        `SFOD_OP_SMALL_UNIT_WIPE: decode = frame(1, 0, 0, 0, 0, 0, 1, 0, 0, `SFOD_DS_NONE);
        // R8: half block.
        `SFOD_OP_HALF_BLOCK_WIPE: decode = frame(1, 0, 0, 0, 0, 0, 1, 0, 0, `SFOD_DS_NONE);
        // R9: full block.
        `SFOD_OP_FULL_BLOCK_WIPE: decode = frame(1, 0, 0, 0, 0, 0, 1, 0, 0, `SFOD_DS_NONE);
        // R24: chip wipe aliases.
        `SFOD_OP_CHIP_WIPE, `SFOD_OP_CHIP_WIPE_ALT:
          decode = frame(0, 0, 0, 0, 0, 0, 1, 0, 0, `SFOD_DS_NONE);
        `SFOD_OP_PAGE_WRITE: decode = frame(1, 0, 0, 0, 0, 1, 1, 0, 0, `SFOD_DS_MANY);
        // R10: dual page write.
        `SFOD_OP_DUAL_PAGE_WRITE: decode = frame(1, 0, 0, 1, 0, 1, 1, 0, 0, `SFOD_DS_MANY);
        // R11: quad page write.
        `SFOD_OP_QUAD_PAGE_WRITE: decode = frame(1, 0, 0, 2, 0, 1, 1, 1, 0, `SFOD_DS_MANY);
        // R24: pause and continue aliases, plus latch, volatile, reset, sleep and burst opcodes.
        `SFOD_OP_PAUSE_CMD, `SFOD_OP_PAUSE_CMD_ALT, `SFOD_OP_CONTINUE_CMD,
        `SFOD_OP_CONTINUE_CMD_ALT, `SFOD_OP_WRITE_LATCH_SET, `SFOD_OP_WRITE_LATCH_CLEAR,
        `SFOD_OP_VOLATILE_LATCH_SET, `SFOD_OP_RESET_ARM, `SFOD_OP_RESET,
        `SFOD_OP_DEEP_SLEEP_ENTER, `SFOD_OP_BURST_LEN_SET:
          decode = frame(0, 0, 0, 0, 0, 0, 0, 0, 0, `SFOD_DS_NONE);
        `SFOD_OP_SECURE_AREA_WIPE: decode = frame(1, 0, 0, 0, 0, 0, 1, 0, 0, `SFOD_DS_NONE);
        `SFOD_OP_SECURE_AREA_WRITE: decode = frame(1, 0, 0, 0, 0, 1, 1, 0, 0, `SFOD_DS_MANY);
        // R15: security fetch.
        `SFOD_OP_SECURE_AREA_FETCH: decode = frame(1, 1, 0, 0, 1, 0, 0, 0, 1, `SFOD_DS_MANY);
        // R16: low status.
        `SFOD_OP_STATE_FETCH_LOW,
        // R17: high status.
        `SFOD_OP_STATE_FETCH_HIGH,
        // R18: configuration.
        `SFOD_OP_CONFIG_FETCH: decode = frame(0, 0, 0, 0, 1, 0, 0, 0, 0, `SFOD_DS_ONE);
        // R19: one dummy byte.
        `SFOD_OP_ACTIVITY_INTERRUPT_ARM: decode = frame(0, 1, 0, 0, 0, 0, 0, 0, 0, `SFOD_DS_NONE);
        // R20: two data bytes.
        `SFOD_OP_STATE_STORE: decode = frame(0, 0, 0, 0, 0, 1, 1, 0, 0, `SFOD_DS_TWO);
        `SFOD_OP_CONFIG_STORE: decode = frame(0, 0, 0, 0, 0, 1, 1, 0, 0, `SFOD_DS_ONE);
        // R21: identification.
        `SFOD_OP_IDENT_TRIPLET_FETCH: decode = frame(0, 0, 0, 0, 1, 0, 0, 0, 0, `SFOD_DS_MANY);
        `SFOD_OP_MAKER_PART_FETCH: decode = frame(1, 0, 0, 0, 1, 0, 0, 0, 0, `SFOD_DS_MANY);
        `SFOD_OP_DUAL_MAKER_PART_FETCH: decode = frame(1, 1, 1, 1, 1, 0, 0, 0, 0, `SFOD_DS_MANY);
        `SFOD_OP_QUAD_MAKER_PART_FETCH: decode = frame(1, 1, 2, 2, 1, 0, 0, 1, 0, `SFOD_DS_MANY);
        // R22: wake with address.
        `SFOD_OP_WAKE_IDENT_FETCH: decode = frame(1, 0, 0, 0, 1, 0, 0, 0, 0, `SFOD_DS_MANY);
        `SFOD_OP_UNIQUE_SERIAL_FETCH: decode = frame(0, 4, 0, 0, 1, 0, 0, 0, 1, `SFOD_DS_MANY);
        default: decode = 16'h0000;
      endcase
    end
  endfunction

  // Folds alias opcodes onto one code.
  function [7:0] canon;
    input [7:0] op;
    begin
      case (op)
        `SFOD_OP_CHIP_WIPE_ALT: canon = `SFOD_OP_CHIP_WIPE;
        `SFOD_OP_PAUSE_CMD_ALT: canon = `SFOD_OP_PAUSE_CMD;
        `SFOD_OP_CONTINUE_CMD_ALT: canon = `SFOD_OP_CONTINUE_CMD;
        default: canon = op;
      endcase
    end
  endfunction

  reg sclk_s1_q, sclk_s2_q, sclk_s3_q;
  reg cs_s1_q, cs_s2_q, cs_s3_q;
  reg [3:0] io_s1_q, io_s2_q;
  reg [6:0] state_q;
  reg [15:0] info_q;
  reg [7:0] opc_q;
  reg [7:0] sr_q;
  reg [3:0] bitcnt_q;
  reg [2:0] bytecnt_q;
  reg [1:0] dcnt_q;
  reg [1:0] outidx_q;
  reg [7:0] osr_q;
  reg [3:0] ocnt_q;
  reg [23:0] addr_q;
  reg wel_q;
  reg vol_q;
  wire rise = sclk_s2_q && !sclk_s3_q;
  wire fall = !sclk_s2_q && sclk_s3_q;
  wire cs_rise = cs_s2_q && !cs_s3_q;
  wire [15:0] info_new = decode(sr_d);
  wire [1:0] lane_sel = (state_q == ST_OP) ? `SFOD_LN_X1 :
    (state_q == ST_DIN) ? info_q[`SFOD_F_DLANE_HI:`SFOD_F_DLANE_LO] :
    info_q[`SFOD_F_ALANE_HI:`SFOD_F_ALANE_LO];
  wire [3:0] lanes = (lane_sel == `SFOD_LN_X4) ? 4'h4 : (lane_sel == `SFOD_LN_X2) ? 4'h2 : 4'h1;
  wire [1:0] olane = info_q[`SFOD_F_DLANE_HI:`SFOD_F_DLANE_LO];
  wire [3:0] olanes = (olane == `SFOD_LN_X4) ? 4'h4 : (olane == `SFOD_LN_X2) ? 4'h2 : 4'h1;
  wire [1:0] dspec = info_q[`SFOD_F_DSPEC_HI:`SFOD_F_DSPEC_LO];
  reg [7:0] sr_d;
  reg [7:0] out_byte;
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop = fall && (state_q == ST_DOUT) && (ocnt_q == 4'h0) && info_q[`SFOD_F_FIFO];
  wire frame_ok;
  wire [6:0] data_state;

  assign o_write_latch_flag = wel_q;
  // R25: exact byte boundary.
  assign frame_ok = (bitcnt_q == 4'h0) && ((state_q == ST_DONE) ||
    ((state_q == ST_DIN) && (dcnt_q != 2'h0) &&
    ((dspec != `SFOD_DS_TWO) || (dcnt_q == 2'h2))));
  assign data_state = info_q[`SFOD_F_OUT] ? ST_DOUT : info_q[`SFOD_F_IN] ? ST_DIN : ST_DONE;

  sfod_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW($clog2(FIFO_DEPTH))
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_flush(cs_s2_q),
    .i_data(i_rd_data),
    .i_valid(i_rd_valid),
    .o_ready(o_rd_ready),
    .o_data(fifo_data),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop)
  );

  always @* begin
    case (lanes)
      4'h4: sr_d = {sr_q[3:0], io_s2_q};
      4'h2: sr_d = {sr_q[5:0], io_s2_q[1:0]};
      default: sr_d = {sr_q[6:0], io_s2_q[0]};
    endcase
  end

  always @* begin
    out_byte = `SFOD_IDLE_BYTE;
    if (info_q[`SFOD_F_FIFO]) begin
      out_byte = fifo_valid ? fifo_data : `SFOD_IDLE_BYTE;
    end else if (opc_q == `SFOD_OP_STATE_FETCH_LOW) begin
      // R28: busy and latch bits.
      out_byte = {i_status_low_upper, wel_q, i_busy_flag};
    end else if (opc_q == `SFOD_OP_STATE_FETCH_HIGH) begin
      out_byte = i_status_high;
    end else if (opc_q == `SFOD_OP_CONFIG_FETCH) begin
      out_byte = i_config;
    end else if (opc_q == `SFOD_OP_WAKE_IDENT_FETCH) begin
      out_byte = WAKE_IDENT;
    end else if (opc_q == `SFOD_OP_IDENT_TRIPLET_FETCH) begin
      // R21: maker then device.
      out_byte = (outidx_q == 2'h0) ? MAKER_CODE :
        (outidx_q == 2'h1) ? DEVICE_CODE[15:8] : DEVICE_CODE[7:0];
    end else begin
      out_byte = outidx_q[0] ? DEVICE_CODE[7:0] : MAKER_CODE;
    end
  end

  always @(posedge i_clk) begin
    sclk_s1_q <= i_sclk;
    sclk_s2_q <= sclk_s1_q;
    sclk_s3_q <= sclk_s2_q;
    cs_s1_q <= i_cs_n;
    cs_s2_q <= cs_s1_q;
    cs_s3_q <= cs_s2_q;
    io_s1_q <= i_io;
    io_s2_q <= io_s1_q;
  end

  always @(posedge i_clk) begin
    o_cmd_valid <= 1'b0;
    o_wr_valid <= 1'b0;
    if (i_reset) begin
      state_q <= ST_OP;
      info_q <= 16'h0000;
      opc_q <= 8'h00;
      sr_q <= 8'h00;
      bitcnt_q <= 4'h0;
      bytecnt_q <= 3'h0;
      dcnt_q <= 2'h0;
      outidx_q <= 2'h0;
      osr_q <= 8'h00;
      ocnt_q <= 4'h0;
      addr_q <= 24'h00_0000;
      wel_q <= 1'b0;
      vol_q <= 1'b0;
      o_io <= 4'h0;
      o_io_oe_n <= 4'hF;
      o_cmd_code <= 8'h00;
      o_cmd_addr <= 24'h00_0000;
      o_cmd_volatile <= 1'b0;
      o_wr_byte <= 8'h00;
    end else begin
      // R27: latch clears on completion.
      if (i_op_done) begin
        wel_q <= 1'b0;
      end
      if (cs_s2_q) begin
        state_q <= ST_OP;
        bitcnt_q <= 4'h0;
        dcnt_q <= 2'h0;
        outidx_q <= 2'h0;
        ocnt_q <= 4'h0;
        o_io_oe_n <= 4'hF;
        if (cs_rise && frame_ok && (state_q != ST_IGNORE)) begin
          case (opc_q)
            // R12: latch set.
            `SFOD_OP_WRITE_LATCH_SET: wel_q <= 1'b1;
            // R13: latch clear.
            `SFOD_OP_WRITE_LATCH_CLEAR: wel_q <= i_op_done ? 1'b0 : 1'b0;
            // R14: volatile arm.
            `SFOD_OP_VOLATILE_LATCH_SET: vol_q <= 1'b1;
            default: begin
              if (!info_q[`SFOD_F_WR] || wel_q ||
                  (vol_q && (opc_q == `SFOD_OP_STATE_STORE))) begin
                o_cmd_valid <= 1'b1;
                o_cmd_code <= canon(opc_q);
                o_cmd_addr <= addr_q;
                o_cmd_volatile <= vol_q && (opc_q == `SFOD_OP_STATE_STORE);
              end
              if (opc_q == `SFOD_OP_STATE_STORE) begin
                vol_q <= 1'b0;
              end
            end
          endcase
        end
      end else if (rise && (state_q != ST_IGNORE) && (state_q != ST_DOUT)) begin
        if (state_q == ST_DONE) begin
          // R25: extra clocks spoil the frame.
          state_q <= ST_IGNORE;
        end else if (bitcnt_q + lanes == 4'h8) begin
          bitcnt_q <= 4'h0;
          sr_q <= 8'h00;
          if (state_q == ST_OP) begin
            info_q <= info_new;
            opc_q <= sr_d;
            if (!info_new[`SFOD_F_VALID] || (info_new[`SFOD_F_QUAD] && !i_quad_allow_bit)) begin
              // R23: unknown or locked opcode.
              state_q <= ST_IGNORE;
              // R26: quad needs allow bit.
            end else if (info_new[`SFOD_F_ADDR3]) begin
              state_q <= ST_ADDR;
              bytecnt_q <= `SFOD_ADDR_BYTES;
            end else if (info_new[`SFOD_F_DUMMY_HI:`SFOD_F_DUMMY_LO] != 3'h0) begin
              state_q <= ST_DUMMY;
              bytecnt_q <= info_new[`SFOD_F_DUMMY_HI:`SFOD_F_DUMMY_LO];
            end else begin
              state_q <= info_new[`SFOD_F_OUT] ? ST_DOUT : info_new[`SFOD_F_IN] ? ST_DIN : ST_DONE;
            end
          end else if (state_q == ST_DIN) begin
            o_wr_valid <= 1'b1;
            o_wr_byte <= sr_d;
            dcnt_q <= (dcnt_q == 2'h3) ? dcnt_q : dcnt_q + 2'h1;
            if ((dspec == `SFOD_DS_ONE) || ((dspec == `SFOD_DS_TWO) && (dcnt_q == 2'h1))) begin
              state_q <= ST_DONE;
            end
          end else begin
            if (state_q == ST_ADDR) begin
              addr_q <= {addr_q[15:0], sr_d};
            end
            bytecnt_q <= bytecnt_q - 3'h1;
            if (bytecnt_q == 3'h1) begin
              if ((state_q == ST_ADDR) &&
                  (info_q[`SFOD_F_DUMMY_HI:`SFOD_F_DUMMY_LO] != 3'h0)) begin
                state_q <= ST_DUMMY;
                bytecnt_q <= info_q[`SFOD_F_DUMMY_HI:`SFOD_F_DUMMY_LO];
              end else begin
                state_q <= data_state;
                if (info_q[`SFOD_F_FIFO]) begin
                  // R1: fetch request at data start.
                  o_cmd_valid <= 1'b1;
                  o_cmd_code <= opc_q;
                  o_cmd_addr <= (state_q == ST_ADDR) ? {addr_q[15:0], sr_d} : addr_q;
                  o_cmd_volatile <= 1'b0;
                end
              end
            end
          end
        end else begin
          bitcnt_q <= bitcnt_q + lanes;
          sr_q <= sr_d;
        end
      end else if (fall && (state_q == ST_DOUT)) begin
        // R3: lane drive on falling edge.
        o_io_oe_n <= (olane == `SFOD_LN_X4) ? 4'h0 : (olane == `SFOD_LN_X2) ? 4'hC : 4'hD;
        if (ocnt_q == 4'h0) begin
          outidx_q <= (outidx_q == 2'h3) ? outidx_q : outidx_q + 2'h1;
          osr_q <= out_byte << olanes;
          ocnt_q <= 4'h8 - olanes;
          o_io <= (olane == `SFOD_LN_X4) ? out_byte[7:4] :
            (olane == `SFOD_LN_X2) ? {2'b00, out_byte[7:6]} : {2'b00, out_byte[7], 1'b0};
        end else begin
          osr_q <= osr_q << olanes;
          ocnt_q <= ocnt_q - olanes;
          o_io <= (olane == `SFOD_LN_X4) ? osr_q[7:4] :
            (olane == `SFOD_LN_X2) ? {2'b00, osr_q[7:6]} : {2'b00, osr_q[7], 1'b0};
        end
      end
    end
  end
endmodule // sfod_decoder

// [tb/sfod_decoder_chk.sv]
module sfod_decoder_chk (
  input wire i_clk,
  input wire i_reset,
  input wire i_cs_n,
  input wire i_quad_allow_bit,
  input wire i_op_done,
  input wire [3:0] o_io_oe_n,
  input wire o_cmd_valid,
  input wire [7:0] o_cmd_code,
  input wire o_wr_valid,
  input wire o_write_latch_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  chk_reset_quiet: assert property ($fell(i_reset) |-> o_io_oe_n == 4'hF && !o_write_latch_flag)
    else $error("outputs active after reset");
  chk_lane_codes: assert property (o_io_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0})
    else $error("illegal lane enables");
  chk_idle_float: assert property (i_cs_n [*8] |-> o_io_oe_n == 4'hF)
    else $error("lanes driven while deselected");
  chk_quad_gate: assert property (o_io_oe_n == 4'h0 |-> i_quad_allow_bit)
    else $error("four lanes without quad allow");
  chk_cmd_late: assert property (i_cs_n [*8] |-> !o_cmd_valid)
    else $error("command long after deselect");
  chk_cmd_pulse: assert property (o_cmd_valid |=> !o_cmd_valid [*8])
    else $error("command pulses too close");
  chk_code_hold: assert property (!o_cmd_valid |-> $stable(o_cmd_code))
    else $error("command code moved without pulse");
  chk_wr_pulse: assert property (o_wr_valid |=> !o_wr_valid [*8])
    else $error("write byte pulses too close");
  chk_latch_set: assert property ($rose(o_write_latch_flag) |-> i_cs_n && $past(i_cs_n, 2))
    else $error("latch set inside a frame");
  chk_latch_done: assert property (i_op_done && i_cs_n && $past(i_cs_n, 8) |=> !o_write_latch_flag)
    else $error("latch kept after completion");
  cover property (o_cmd_valid && o_cmd_code == 8'h0B);
  cover property ($rose(o_write_latch_flag));
  cover property (o_io_oe_n == 4'h0);
endmodule // sfod_decoder_chk
bind sfod_decoder sfod_decoder_chk u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(i_cs_n),
  .i_quad_allow_bit(i_quad_allow_bit), .i_op_done(i_op_done), .o_io_oe_n(o_io_oe_n),
  .o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code), .o_wr_valid(o_wr_valid),
  .o_write_latch_flag(o_write_latch_flag));

// [tb/sfod_host_model.sv]
module sfod_host_model (
  input wire logic i_clk,
  input wire logic [3:0] i_io_line,
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'hF;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  task automatic start();
    tick(1);
    o_cs_n = 1'b0;
    tick(4);
  endtask
  // Frames end wherever the host stopped, even mid-byte; released lines show the inverse.
  task automatic stop();
    tick(4);
    o_cs_n = 1'b1;
    o_io = ~o_io;
    tick(16);
  endtask
  task automatic xfer(input logic [7:0] tx, input int ln, input int nclk, input int rd,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nclk; i++) begin
      if (rd != 0) o_io = ~o_io;
      else if (ln == 1) o_io = {~o_io[3:1], tx[7 - i]};
      else if (ln == 2) o_io = {~o_io[3:2], tx[7 - 2 * i -: 2]};
      else o_io = tx[7 - 4 * i -: 4];
      tick(4);
      o_sclk = 1'b1;
      tick(4);
      if (ln == 1) rx = {rx[6:0], i_io_line[1]};
      else if (ln == 2) rx = {rx[5:0], i_io_line[1:0]};
      else rx = {rx[3:0], i_io_line};
      o_sclk = 1'b0;
    end
  endtask
endmodule // sfod_host_model

// [tb/test_serial_flash_opcode_decoder.sv]
module test_serial_flash_opcode_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] op; int na, nd, al, dl, nw, rd, write_latch_flag, pl; logic [7:0] code, exp;} sfod_row_t;
  localparam logic [23:0] ADDR = 24'h12_3456;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic quad = 1'b1;
  logic done = 1'b0;
  logic act = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [22:0] stv = 23'h6D_6C93;
  logic sclk, cs_n, rd_ready, cmd_valid, cmd_vol, wr_valid, latch;
  logic [3:0] h_io, d_io, d_oe_n, io_line;
  logic [7:0] cmd_code, wr_byte, rx;
  logic [23:0] cmd_addr;
  int n_cmd = 0;
  int n_mismatch = 0;
  int n_compared = 0;
  sfod_row_t rows [22] = '{
    '{8'h0B,3,1,1,1,0,1,0,1,8'h0B,8'h00}, '{8'h03,3,0,1,1,0,1,0,1,8'h03,8'h00},
    '{8'h3B,3,1,1,2,0,1,0,1,8'h3B,8'h00}, '{8'hBB,3,1,2,2,0,1,0,1,8'hBB,8'h00},
    '{8'h6B,3,1,1,4,0,1,0,1,8'h6B,8'h00}, '{8'hEB,3,1,4,4,0,1,0,1,8'hEB,8'h00},
    '{8'h48,3,1,1,1,0,1,0,1,8'h48,8'h00}, '{8'h05,0,0,1,1,0,1,1,2,8'h00,8'hB7},
    '{8'h35,0,0,1,1,0,1,0,2,8'h00,8'h6C}, '{8'h15,0,0,1,1,0,1,0,2,8'h00,8'h93},
    '{8'h9F,0,0,1,1,0,1,0,2,8'h00,8'h5A}, '{8'hAB,3,0,1,1,0,1,0,2,8'h00,8'h3C},
    '{8'h20,3,0,1,1,0,0,1,1,8'h20,8'h00}, '{8'h52,3,0,1,1,0,0,1,1,8'h52,8'h00},
    '{8'hD8,3,0,1,1,0,0,1,1,8'hD8,8'h00}, '{8'hA2,3,0,1,2,1,0,1,1,8'hA2,8'hC3},
    '{8'h32,3,0,1,4,1,0,1,1,8'h32,8'h5E}, '{8'h01,0,0,1,1,2,0,1,1,8'h01,8'h0F},
    '{8'h25,0,1,1,1,0,0,0,1,8'h25,8'h00}, '{8'hC7,0,0,1,1,0,0,1,1,8'h60,8'h00},
    '{8'hB0,0,0,1,1,0,0,0,1,8'h75,8'h00}, '{8'h30,0,0,1,1,0,0,0,1,8'h7A,8'h00}};
  always #12.5 clk = ~clk;
  assign io_line = (d_io & ~d_oe_n) | (h_io & d_oe_n);
  sfod_host_model u_host (.i_clk(clk), .i_io_line(io_line), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_io(h_io));
  sfod_decoder u_dut (.i_clk(clk), .i_reset(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io_line),
    .o_io(d_io), .o_io_oe_n(d_oe_n), .i_busy_flag(stv[22]), .i_status_low_upper(stv[21:16]),
    .i_status_high(stv[15:8]), .i_config(stv[7:0]), .i_quad_allow_bit(quad), .i_op_done(done),
    .i_rd_data(cnt), .i_rd_valid(act && cnt < 8'h28), .o_rd_ready(rd_ready),
    .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code), .o_cmd_addr(cmd_addr),
    .o_cmd_volatile(cmd_vol), .o_wr_valid(wr_valid), .o_wr_byte(wr_byte),
    .o_write_latch_flag(latch));
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (cmd_valid === 1'b1) begin
      act <= 1'b1;
      cnt <= 8'h00;
    end else if (cs_n) act <= 1'b0;
    else if (act && cnt < 8'h28 && rd_ready) cnt <= cnt + 8'h01;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic xb(input logic [7:0] b, input int ln, input int rd);
    u_host.xfer(b, ln, 8 / ln, rd, rx);
  endtask
  task automatic frame1(input logic [7:0] op);
    u_host.start();
    xb(op, 1, 0);
    u_host.stop();
  endtask
  task automatic run_row(input sfod_row_t r);
    int c0;
    if (r.write_latch_flag != 0) begin
      frame1(8'h06);
      check(latch, 1'b1, "latch set");
    end
    c0 = n_cmd;
    u_host.start();
    xb(r.op, 1, 0);
    for (int i = 0; i < r.na; i++) xb(ADDR[23 - 8 * i -: 8], r.al, 0);
    for (int i = 0; i < r.nd; i++) xb(8'h00, r.al, 0);
    for (int i = 0; i < r.nw; i++) xb(r.exp, r.dl, 0);
    if (r.rd != 0) xb(8'hFF, r.dl, 1);
    if (r.rd == 1) check(rx, r.exp, "read byte");
    if (r.pl == 0) check(d_oe_n, 4'hF, "refused lanes");
    u_host.stop();
    if (r.pl < 2) check(n_cmd - c0, r.pl, "command pulses");
    if (r.pl == 1) check(cmd_code, r.code, "command code");
    if (r.pl == 1 && r.na == 3) check(cmd_addr, ADDR, "command address");
    if (r.nw == 1) check(wr_byte, r.exp, "write byte");
    if (r.write_latch_flag != 0) begin
      done = 1'b1;
      u_host.tick(1);
      done = 1'b0;
      u_host.tick(2);
      check(latch, 1'b0, "latch after done");
    end
  endtask
  initial begin
    u_host.tick(8);
    rst = 1'b0;
    u_host.tick(8);
    foreach (rows[k]) run_row(rows[k]);
    frame1(8'h06);
    frame1(8'h04);
    check(latch, 1'b0, "latch clear");
    frame1(8'h50);
    run_row('{8'h01, 0, 0, 1, 1, 2, 0, 0, 1, 8'h01, 8'hF0});
    check(cmd_vol, 1'b1, "volatile store");
    u_host.start();
    xb(8'h06, 1, 0);
    u_host.xfer(8'h00, 1, 4, 0, rx);
    u_host.stop();
    check(latch, 1'b0, "partial frame");
    run_row('{8'h5A, 0, 0, 1, 1, 0, 2, 0, 0, 8'h00, 8'h00});
    quad = 1'b0;
    run_row('{8'h6B, 3, 1, 1, 4, 0, 2, 0, 0, 8'h00, 8'h00});
    quad = 1'b1;
    u_host.start();
    xb(8'h03, 1, 0);
    for (int i = 0; i < 3; i++) xb(ADDR[23 - 8 * i -: 8], 1, 0);
    u_host.tick(80);
    check(rd_ready, 1'b0, "buffer full");
    for (int i = 0; i <= 40; i++) begin
      xb(8'hFF, 1, 1);
      check(rx, (i < 40) ? 32'(i) : 32'hFF, "stream byte");
    end
    u_host.stop();
    frame1(8'h06);
    rst = 1'b1;
    u_host.tick(8);
    check({latch, d_oe_n, cmd_valid}, 6'h1E, "reset state");
    rst = 1'b0;
    u_host.tick(8);
    final_report();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule // test_serial_flash_opcode_decoder
